// ---- common/ram_block_pkg.sv ----
package ram_block_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes of the storage array and of the port fields
  localparam int MEM_BITS   = 4608;
  localparam int PLAIN_BITS = 4096;
  localparam int MAX_W      = 36;
  localparam int ADDR_W     = 12;
  localparam int BE_W       = 4;
  localparam int TAP_LEN_W  = 12;
  localparam int TAP_CNT_W  = 6;
  localparam int PLAIN_LANE = 8;
  localparam int PAR_LANE   = 9;

  // Half of the array for two single-port memories in one block
  localparam logic [13:0] PLAIN_HALF  = 14'h0800;
  localparam logic [13:0] PARITY_HALF = 14'h0900;
  localparam logic [13:0] BASE_NONE   = 14'h3fff;

  // Reset value of the shift write pointer
  localparam logic [ADDR_W-1:0] PTR_RST = 12'h000;

  ////////////////////////////////////////////////////////////////////////////
  // Memory modes, clock modes and port shapes
  typedef enum logic [1:0] {
    MODE_TDP   = 2'h0,
    MODE_SDP   = 2'h1,
    MODE_SHIFT = 2'h2,
    MODE_SP    = 2'h3
  } ram_mode_t;

  typedef enum logic [1:0] {
    CLK_INDEP = 2'h0,
    CLK_INOUT = 2'h1,
    CLK_RDWR  = 2'h2
  } clk_mode_t;

  typedef enum logic [3:0] {
    W_1  = 4'h0,
    W_2  = 4'h1,
    W_4  = 4'h2,
    W_8  = 4'h3,
    W_16 = 4'h4,
    W_32 = 4'h5,
    W_9  = 4'h6,
    W_18 = 4'h7,
    W_36 = 4'h8
  } width_t;

  ////////////////////////////////////////////////////////////////////////////
  // Port shape decoding
  function automatic logic [5:0] width_bits(width_t c);
    unique case (c)
      W_1:     width_bits = 6'h01;
      W_2:     width_bits = 6'h02;
      W_4:     width_bits = 6'h04;
      W_8:     width_bits = 6'h08;
      W_16:    width_bits = 6'h10;
      W_32:    width_bits = 6'h20;
      W_9:     width_bits = 6'h09;
      W_18:    width_bits = 6'h12;
      W_36:    width_bits = 6'h24;
      default: width_bits = 6'h00;
    endcase
  endfunction

  function automatic logic is_parity(width_t c);
    is_parity = (c == W_9) || (c == W_18) || (c == W_36);
  endfunction

  function automatic logic is_wide(width_t c);
    is_wide = (c == W_32) || (c == W_36);
  endfunction

  function automatic logic be_capable(width_t c);
    be_capable = (c == W_16) || (c == W_18) || is_wide(c);
  endfunction

  // First bit of a word; BASE_NONE when a parity-shape word lies outside the array, plain shapes wrap at 4096 bits
  function automatic logic [13:0] word_base(width_t c, logic [11:0] addr,
                                            logic split, logic upper);
    logic [17:0] full;
    logic [13:0] b;
    logic [13:0] half;
    full = 18'(addr) * 18'(width_bits(c));
    half = is_parity(c) ? PARITY_HALF : PLAIN_HALF;
    if (!is_parity(c))
      b = {2'h0, full[11:0]};
    else if (full > 18'(MEM_BITS - int'(width_bits(c))))
      b = BASE_NONE;
    else
      b = full[13:0];
    if (split && b != BASE_NONE) begin
      if (b >= half)
        b = b - half;
      if (upper)
        b = b + half;
    end
    word_base = b;
  endfunction

endpackage

// ---- src/reg_stage.sv ----
`timescale 1ns/1ns
module reg_stage
  import ram_block_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             arst_n,
  input  wire logic             clr,
  input  wire logic             load,
  input  wire logic             bypass,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] q;
  } stage_t;

  stage_t stage_r;
  stage_t stage_nxt;

  // Load on the port's clock tick, or follow every cycle when bypassed
  always_comb begin
    stage_nxt = stage_r;
    if (load || bypass)
      stage_nxt.q = d;
  end

  // Clear acts at once, without waiting for an edge
  always_ff @(posedge clock or negedge arst_n or posedge clr) begin
    if (!arst_n)
      stage_r <= '0;
    else if (clr)
      stage_r <= '0;
    else
      stage_r <= stage_nxt;
  end

  assign q = stage_r.q;

endmodule

// ---- src/embedded_ram_block.sv ----
`timescale 1ns/1ns
// How it works
// - Shift mode reads a location before writing it in the same cycle.
// - Shift mode advances one word position per tick while ce_in_a is high; addresses are not used.
// - Shapes 4096x1 up to 128x36 are offered on each port.
// - 32- and 36-bit shapes are refused in true dual-port mode.
// - Port widths may differ but plain and parity families never mix.
// - Byte enables act only on 16, 18, 32 and 36-bit write ports.
// - Lanes whose enable is low keep their stored bits.
// - Enable bit zero selects the lowest lane; 9-bit lanes for parity.
// - All inputs are registered; only the output stage may be bypassed.
// - Independent mode: tick A clocks port A, tick B clocks port B.
// - Input/output mode: tick A clocks inputs, tick B clocks outputs.
// - Read/write mode: tick A clocks the writer, tick B the reader.
// - In simple dual-port mode the read-enable registers ignore clr_in_a and clr_in_b; only arst_n clears them.
// - Single-port never reads while writing; split mode gives two halves.
// - The write happens one cycle after capture, timed internally.
// - True dual-port runs both ports at once, each on its own tick only in independent mode.
module embedded_ram_block
  import ram_block_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 arst_n,
  input  wire ram_mode_t            mode,
  input  wire clk_mode_t            clk_mode,
  input  wire logic                 sp_split,
  input  wire width_t               width_a,
  input  wire width_t               width_b,
  input  wire logic [TAP_LEN_W-1:0] tap_len,
  input  wire logic [TAP_CNT_W-1:0] tap_cnt,
  input  wire logic                 tick_a,
  input  wire logic                 tick_b,
  input  wire logic                 ce_in_a,
  input  wire logic                 ce_out_a,
  input  wire logic                 ce_in_b,
  input  wire logic                 ce_out_b,
  input  wire logic                 clr_in_a,
  input  wire logic                 clr_out_a,
  input  wire logic                 clr_in_b,
  input  wire logic                 clr_out_b,
  input  wire logic                 bypass_a,
  input  wire logic                 bypass_b,
  input  wire logic                 we_a,
  input  wire logic                 re_a,
  input  wire logic [ADDR_W-1:0]    addr_a,
  input  wire logic [MAX_W-1:0]     din_a,
  input  wire logic [BE_W-1:0]      be_a,
  input  wire logic                 we_b,
  input  wire logic                 re_b,
  input  wire logic [ADDR_W-1:0]    addr_b,
  input  wire logic [MAX_W-1:0]     din_b,
  input  wire logic [BE_W-1:0]      be_b,
  output logic      [MAX_W-1:0]     q_a,
  output logic      [MAX_W-1:0]     q_b,
  output logic                      cfg_err
);

  localparam int IN_W = 1 + ADDR_W + MAX_W + BE_W;
  typedef struct packed {
    logic [MEM_BITS-1:0] mem;
    logic [ADDR_W-1:0]   ptr;
    logic                pend_a;
    logic                pend_b;
    logic [MAX_W-1:0]    rd_a;
    logic [MAX_W-1:0]    rd_b;
    logic                cfg_err;
  } core_t;
  core_t core_r;
  core_t core_nxt;
  logic             in_tick_b;
  logic             out_tick_a;
  logic             ld_in_a;
  logic             ld_in_b;
  logic             sdp_like;
  logic             re_clr_a;
  logic             re_clr_b;
  logic [IN_W-1:0]  in_a;
  logic [IN_W-1:0]  in_b;
  logic             re_r_a;
  logic             re_r_b;
  ////////////////////////////////////////////////////////////////////////////
  // Word access helpers
  function automatic logic [MAX_W-1:0] read_word(logic [MEM_BITS-1:0] m,
                                                 logic [13:0] base,
                                                 logic [5:0] w);
    logic [MAX_W-1:0] r;
    r = '0;
    for (int i = 0; i < MAX_W; i++) begin
      if (i < int'(w) && int'(base) + i < MEM_BITS)
        r[i] = m[int'(base) + i];
    end
    read_word = r;
  endfunction
  function automatic logic [MEM_BITS-1:0] write_word(
      logic [MEM_BITS-1:0] m, logic [13:0] base, width_t c,
      logic [MAX_W-1:0] d, logic [BE_W-1:0] be);
    logic [MEM_BITS-1:0] r;
    int                  lane;
    logic                en;
    r = m;
    for (int i = 0; i < MAX_W; i++) begin
      lane = is_parity(c) ? i / PAR_LANE : i / PLAIN_LANE;
      en = be_capable(c) ? be[lane] : 1'b1;
      if (en && i < int'(width_bits(c)) && base != BASE_NONE &&
          int'(base) + i < MEM_BITS)
        r[int'(base) + i] = d[i];
    end
    write_word = r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Clock mode steering of the two ticks
  // independent mode ticks
  // inputs on A, outputs on B
  assign in_tick_b  = (clk_mode == CLK_INOUT) ? tick_a : tick_b;
  assign out_tick_a = (clk_mode == CLK_INDEP) ? tick_a : tick_b;
  assign ld_in_a    = tick_a && ce_in_a;
  assign ld_in_b    = in_tick_b && ce_in_b;
  assign sdp_like = (mode == MODE_SDP);
  assign re_clr_a = sdp_like ? 1'b0 : clr_in_a;
  assign re_clr_b = sdp_like ? 1'b0 : clr_in_b;
  ////////////////////////////////////////////////////////////////////////////
  // Input registers, always present
  // registered inputs A
  reg_stage #(.WIDTH(IN_W)) u_in_a (
    .clock  (clock),
    .arst_n (arst_n),
    .clr    (clr_in_a),
    .load   (ld_in_a),
    .bypass (1'b0),
    .d      ({we_a, addr_a, din_a, be_a}),
    .q      (in_a)
  );
  reg_stage #(.WIDTH(1)) u_re_a (
    .clock  (clock),
    .arst_n (arst_n),
    .clr    (re_clr_a),
    .load   (ld_in_a),
    .bypass (1'b0),
    .d      (re_a),
    .q      (re_r_a)
  );
  reg_stage #(.WIDTH(IN_W)) u_in_b (
    .clock  (clock),
    .arst_n (arst_n),
    .clr    (clr_in_b),
    .load   (ld_in_b),
    .bypass (1'b0),
    .d      ({we_b, addr_b, din_b, be_b}),
    .q      (in_b)
  );
  reg_stage #(.WIDTH(1)) u_re_b (
    .clock  (clock),
    .arst_n (arst_n),
    .clr    (re_clr_b),
    .load   (ld_in_b),
    .bypass (1'b0),
    .d      (re_b),
    .q      (re_r_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Core: configuration check, write strobe, reads and shift taps
  always_comb begin
    logic              err;
    logic [5:0]        wa;
    logic [5:0]        wb;
    logic [13:0]       base_a;
    logic [13:0]       base_b;
    logic              split;
    logic              a_wr;
    logic              a_rd;
    logic              b_wr;
    logic              b_rd;
    logic [MAX_W-1:0]  taps;
    int                len;
    int                t;
    err    = 1'b0;
    wa     = width_bits(width_a);
    wb     = width_bits(width_b);
    split  = (mode == MODE_SP) && sp_split;
    base_a = word_base(width_a, in_a[IN_W-2 -: ADDR_W], split, 1'b0);
    base_b = word_base(width_b, in_b[IN_W-2 -: ADDR_W], split, 1'b1);
    taps   = '0;
    len    = int'(tap_len) * int'(tap_cnt);
    t      = 0;
    core_nxt = core_r;
    if (wa == 6'h00 || wb == 6'h00)
      err = 1'b1;
    if (mode == MODE_TDP && (is_wide(width_a) || is_wide(width_b)))
      err = 1'b1;
    if ((mode == MODE_TDP || mode == MODE_SDP || split) &&
        is_parity(width_a) != is_parity(width_b))
      err = 1'b1;
    if (mode == MODE_SHIFT &&
        (len == 0 || len * int'(wa) > MEM_BITS ||
         int'(tap_cnt) * int'(wa) > MAX_W))
      err = 1'b1;
    core_nxt.cfg_err = err;
    core_nxt.pend_a = ld_in_a;
    core_nxt.pend_b = ld_in_b;
    a_wr = core_r.pend_a && in_a[IN_W-1] && !core_r.cfg_err;
    b_wr = core_r.pend_b && in_b[IN_W-1] && !core_r.cfg_err &&
           (mode == MODE_TDP || split);
    a_rd = core_r.pend_a && re_r_a && !core_r.cfg_err &&
           (mode == MODE_TDP || (mode == MODE_SP && !in_a[IN_W-1]));
    b_rd = core_r.pend_b && re_r_b && !core_r.cfg_err &&
           (mode == MODE_TDP || mode == MODE_SDP ||
            (split && !in_b[IN_W-1]));
    if (mode == MODE_SHIFT) begin
      if (core_r.pend_a && !core_r.cfg_err) begin
        for (int k = 0; k < MAX_W; k++) begin
          if (k < int'(tap_cnt)) begin
            t = int'(core_r.ptr) - (k + 1) * int'(tap_len);
            if (t < 0)
              t = t + len;
            for (int i = 0; i < MAX_W; i++) begin
              if (i < int'(wa) && k * int'(wa) + i < MAX_W &&
                  t * int'(wa) + i < MEM_BITS)
                taps[k * int'(wa) + i] = core_r.mem[t * int'(wa) + i];
            end
          end
        end
        core_nxt.rd_a = taps;
        core_nxt.mem = write_word(core_r.mem,
                                  14'(int'(core_r.ptr) * int'(wa)),
                                  width_a, in_a[IN_W-2-ADDR_W -: MAX_W],
                                  {BE_W{1'b1}});
        if (int'(core_r.ptr) >= len - 1)
          core_nxt.ptr = PTR_RST;
        else
          core_nxt.ptr = core_r.ptr + 12'h001;
      end
    end else begin
      if (a_rd)
        core_nxt.rd_a = read_word(core_r.mem, base_a, wa);
      if (b_rd)
        core_nxt.rd_b = read_word(core_r.mem, base_b, wb);
      if (a_wr)
        core_nxt.mem = write_word(core_nxt.mem, base_a, width_a,
                                  in_a[IN_W-2-ADDR_W -: MAX_W],
                                  in_a[BE_W-1:0]);
      // Port B wins a same-bit collision
      if (b_wr)
        core_nxt.mem = write_word(core_nxt.mem, base_b, width_b,
                                  in_b[IN_W-2-ADDR_W -: MAX_W],
                                  in_b[BE_W-1:0]);
    end
  end
  // Core state register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      core_r <= '0;
    else
      core_r <= core_nxt;
  end
  assign cfg_err = core_r.cfg_err;
  ////////////////////////////////////////////////////////////////////////////
  // Output registers, the only bypassable stage
  // clear zeroes A
  reg_stage #(.WIDTH(MAX_W)) u_out_a (
    .clock  (clock),
    .arst_n (arst_n),
    .clr    (clr_out_a),
    .load   (out_tick_a && ce_out_a),
    .bypass (bypass_a),
    .d      (core_r.rd_a),
    .q      (q_a)
  );
  reg_stage #(.WIDTH(MAX_W)) u_out_b (
    .clock  (clock),
    .arst_n (arst_n),
    .clr    (clr_out_b),
    .load   (tick_b && ce_out_b),
    .bypass (bypass_b),
    .d      (core_r.rd_b),
    .q      (q_b)
  );
endmodule

// ---- tb/ram_block_chk_sva.sv ----
`timescale 1ns/1ns
module ram_block_chk
  import ram_block_pkg::*;
(
  input wire logic                 clock,
  input wire logic                 arst_n,
  input wire ram_mode_t            mode,
  input wire clk_mode_t            clk_mode,
  input wire width_t               width_a,
  input wire width_t               width_b,
  input wire logic [TAP_CNT_W-1:0] tap_cnt,
  input wire logic                 tick_a,
  input wire logic                 tick_b,
  input wire logic                 ce_out_a,
  input wire logic                 ce_out_b,
  input wire logic                 clr_out_a,
  input wire logic                 clr_out_b,
  input wire logic                 bypass_a,
  input wire logic                 bypass_b,
  input wire logic [MAX_W-1:0]     q_a,
  input wire logic [MAX_W-1:0]     q_b,
  input wire logic                 cfg_err
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);

  ////////////////////////////////////////////////////////////////////////
  // Output clears
  // clear zeroes output
  chk_clr_zero_a: assert property (
    clr_out_a |-> q_a == '0) else $error("q_a not zero in clear");
  chk_clr_zero_b: assert property (
    clr_out_b |-> q_b == '0) else $error("q_b not zero in clear");

  ////////////////////////////////////////////////////////////////////////
  // Output registers move only on their own out tick
  // port A clock
  chk_hold_out_a: assert property (
    clk_mode == CLK_INDEP && $stable(clk_mode) && !bypass_a
    && !$past(bypass_a) && !clr_out_a && !$past(tick_a && ce_out_a)
    |-> $stable(q_a)) else $error("q_a moved without out tick");
  chk_hold_out_b: assert property (
    !bypass_b && !$past(bypass_b) && !clr_out_b
    && !$past(tick_b && ce_out_b)
    |-> $stable(q_b)) else $error("q_b moved without out tick");

  ////////////////////////////////////////////////////////////////////////
  // Shape legality flag
  // wide shapes refused
  chk_tdp_wide: assert property (
    mode == MODE_TDP && (width_a inside {W_32, W_36}
    || width_b inside {W_32, W_36})
    |=> cfg_err) else $error("wide shape in dual-port not flagged");
  chk_family_mix: assert property (
    (mode == MODE_TDP || mode == MODE_SDP)
    && ((width_a inside {W_9, W_18, W_36})
        != (width_b inside {W_9, W_18, W_36}))
    |=> cfg_err) else $error("mixed families not flagged");
  chk_tap_limit: assert property (
    mode == MODE_SHIFT && width_a == W_8 && tap_cnt > 6'h04
    |=> cfg_err) else $error("tap overflow not flagged");
  chk_sdp_wide_ok: assert property (
    mode == MODE_SDP && clk_mode == CLK_RDWR && width_a == W_36
    && width_b == W_36 |=> !cfg_err) else $error("legal wide flagged");

  // Main scenarios reached
  cover property (mode == MODE_SHIFT && tick_a && ce_out_a);
  cover property (mode == MODE_SDP && tick_b && ce_out_b);
  cover property (cfg_err);
endmodule

// ---- tb/user_tick_gen.sv ----
`timescale 1ns/1ns
module user_tick_gen #(
  parameter int DIV = 3
) (
  input  wire logic clock,
  input  wire logic arst_n,
  output logic      tick
);
  typedef struct packed {
    logic [3:0] cnt;
    logic       tick;
  } tick_state_t;
  tick_state_t st_r;
  tick_state_t st_nxt;

  // Divider for a slower port B clock
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = (st_r.cnt == 4'(DIV - 1));
    st_nxt.cnt = st_nxt.tick ? 4'h0 : st_r.cnt + 4'h1;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
  assign tick = st_r.tick;
endmodule

// ---- tb/tb_embedded_ram_block.sv ----
`timescale 1ns/1ns
module tb_embedded_ram_block
  import ram_block_pkg::*;
;
  logic                 clock, arst_n, sp_split, tick_a, tick_b;
  ram_mode_t            mode;
  clk_mode_t            clk_mode;
  width_t               width_a, width_b;
  logic [TAP_LEN_W-1:0] tap_len;
  logic [TAP_CNT_W-1:0] tap_cnt;
  logic                 ce_in_a, ce_out_a, ce_in_b, ce_out_b;
  logic                 clr_in_a, clr_out_a, clr_in_b, clr_out_b;
  logic                 bypass_a, bypass_b, we_a, re_a, we_b, re_b;
  logic [ADDR_W-1:0]    addr_a, addr_b;
  logic [MAX_W-1:0]     din_a, din_b, q_a, q_b;
  logic [BE_W-1:0]      be_a, be_b;
  logic                 cfg_err;
  int                   mismatches, checks_done;

  embedded_ram_block i_embedded_ram_block (.clock, .arst_n, .mode,
    .clk_mode, .sp_split, .width_a, .width_b, .tap_len, .tap_cnt, .tick_a,
    .tick_b, .ce_in_a, .ce_out_a, .ce_in_b, .ce_out_b, .clr_in_a,
    .clr_out_a, .clr_in_b, .clr_out_b, .bypass_a, .bypass_b, .we_a, .re_a,
    .addr_a, .din_a, .be_a, .we_b, .re_b, .addr_b, .din_b, .be_b, .q_a,
    .q_b, .cfg_err);
  user_tick_gen #(.DIV(3)) i_user_tick_gen (.clock, .arst_n,
    .tick(tick_b));

  // Clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////
  // Access tasks
  task automatic chk(input string nm, input logic [MAX_W-1:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wait_tick(input logic b);
    do @(negedge clock); while (!(b ? tick_b : tick_a));
    @(posedge clock);
  endtask

  // Request held until the port's input tick takes it
  task automatic req(input logic b, w, input logic [11:0] ad,
                     input logic [35:0] d, input logic [3:0] e);
    @(posedge clock);
    we_a <= w & !b;
    re_a <= !w & !b;
    ce_in_a <= !b;
    we_b <= w & b;
    re_b <= !w & b;
    ce_in_b <= b;
    {addr_a, addr_b, din_a, din_b, be_a, be_b} <= {ad, ad, d, d, e, e};
    wait_tick(b);
    {we_a, re_a, ce_in_a, we_b, re_b, ce_in_b} <= '0;
  endtask

  // Let the output registers load, then compare
  task automatic peek(input logic b, input logic [35:0] exp, string nm);
    ce_out_a <= !b;
    ce_out_b <= b;
    repeat (3) wait_tick(1'b1);
    ce_out_a <= 1'b0;
    ce_out_b <= 1'b0;
    @(negedge clock);
    chk(nm, b ? q_b : q_a, exp);
  endtask

  task automatic rd(input logic b, input logic [11:0] ad,
                    input logic [35:0] exp, string nm);
    req(b, 1'b0, ad, '0, '0);
    peek(b, exp, nm);
  endtask

  task automatic cfg(input ram_mode_t m, clk_mode_t c, width_t wa, wb,
                     input logic [5:0] n, input logic e);
    @(posedge clock);
    mode     <= m;
    clk_mode <= c;
    width_a  <= wa;
    width_b  <= wb;
    tap_cnt  <= n;
    repeat (3) @(posedge clock);
    @(negedge clock);
    chk("cfg_err", {35'h0, cfg_err}, {35'h0, e});
  endtask

  task automatic final_report;
    $display("checks_done %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Tests
  initial begin
    {mismatches, checks_done} = '0;
    mode = MODE_TDP;
    clk_mode = CLK_INDEP;
    width_a = W_16;
    width_b = W_16;
    {tap_len, tap_cnt, arst_n, tick_a} = {12'h004, 6'h02, 1'b0, 1'b1};
    {sp_split, ce_in_a, ce_out_a, ce_in_b, ce_out_b, clr_in_a, clr_out_a,
     clr_in_b, clr_out_b, bypass_a, bypass_b, we_a, re_a, we_b, re_b,
     addr_a, addr_b, din_a, din_b, be_a, be_b} = '0;
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    @(negedge clock);
    chk("q_a", q_a, '0);
    chk("q_b", q_b, '0);
    // Write on A, read on the slower B; then masked lanes
    req(1'b0, 1'b1, 12'h005, 36'h0_0000_a5c3, 4'hf);
    rd(1'b1, 12'h005, 36'h0_0000_a5c3, "tdp_b");
    req(1'b0, 1'b1, 12'h005, 36'h0_0000_1234, 4'h1);
    rd(1'b0, 12'h005, 36'h0_0000_a534, "mask16");
    req(1'b1, 1'b1, 12'h005, 36'h0_0000_ff00, 4'h2);
    rd(1'b0, 12'h005, 36'h0_0000_ff34, "lane1");
    // Narrow x8 writes ignore byte enables; x16 sees both bytes
    cfg(MODE_TDP, CLK_INOUT, W_8, W_16, 6'h02, 1'b0);
    req(1'b0, 1'b1, 12'h00a, 36'h0_0000_00c3, 4'h0);
    req(1'b0, 1'b1, 12'h00b, 36'h0_0000_003c, 4'h0);
    rd(1'b1, 12'h005, 36'h0_0000_3cc3, "mixed");
    // Illegal shapes
    cfg(MODE_TDP, CLK_INDEP, W_32, W_32, 6'h02, 1'b1);
    cfg(MODE_TDP, CLK_INDEP, W_8, W_9, 6'h02, 1'b1);
    cfg(MODE_SHIFT, CLK_INDEP, W_8, W_8, 6'h05, 1'b1);
    // Shift: 8 wide, length 4, two taps
    cfg(MODE_SHIFT, CLK_INDEP, W_8, W_8, 6'h02, 1'b0);
    for (int i = 0; i < 2; i++) begin
      repeat (12) req(1'b0, 1'b1, 12'h000, i ? 36'h5a : 36'h3c, 4'h0);
      peek(1'b0, i ? 36'h5a5a : 36'h3c3c, "taps");
    end
    // Simple dual-port, 36 wide, 9-bit lanes
    cfg(MODE_SDP, CLK_RDWR, W_36, W_36, 6'h02, 1'b0);
    req(1'b0, 1'b1, 12'h003, 36'h1_2345_6789, 4'hf);
    req(1'b0, 1'b1, 12'h003, 36'hf_ffff_ffff, 4'h5);
    rd(1'b1, 12'h003, 36'h1_27fd_67ff, "lanes9");
    // Clears act at once; then bypassed output
    @(posedge clock);
    {clr_out_a, clr_out_b} <= 2'b11;
    @(negedge clock);
    chk("clr_a", q_a, '0);
    chk("clr_b", q_b, '0);
    @(posedge clock);
    {clr_out_a, clr_out_b, bypass_b} <= 3'b001;
    // Bypassed output follows read data with its enable low
    repeat (2) @(posedge clock);
    @(negedge clock);
    chk("bypass_q", q_b, 36'h1_27fd_67ff);
    rd(1'b1, 12'h003, 36'h1_27fd_67ff, "bypass");
    // Single port write then read
    cfg(MODE_SP, CLK_INDEP, W_8, W_8, 6'h02, 1'b0);
    req(1'b0, 1'b1, 12'h007, 36'h0_0000_0096, 4'h0);
    rd(1'b0, 12'h007, 36'h0_0000_0096, "sp");
    // Two half-size single-port memories; A wraps inside its half
    @(posedge clock);
    sp_split <= 1'b1;
    req(1'b0, 1'b1, 12'h000, 36'h0_0000_0011, 4'h0);
    req(1'b1, 1'b1, 12'h000, 36'h0_0000_0022, 4'h0);
    rd(1'b0, 12'h100, 36'h0_0000_0011, "half_a");
    rd(1'b1, 12'h000, 36'h0_0000_0022, "half_b");
    final_report;
  end

  // Watchdog
  initial begin
    #20000;
    mismatches++;
    final_report;
  end
endmodule

bind embedded_ram_block ram_block_chk i_ram_block_chk (.clock, .arst_n,
  .mode, .clk_mode, .width_a, .width_b, .tap_cnt, .tick_a, .tick_b,
  .ce_out_a, .ce_out_b, .clr_out_a, .clr_out_b, .bypass_a, .bypass_b,
  .q_a, .q_b, .cfg_err);
